// File: common/sep_pkg.sv
// constants shared by the serial memory target logic
// assumes a single 250 MHz system clock samples the two-wire bus pins
package sep_pkg;

    // ----------------------------------------------------------------
    // array and page geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W_DEF = 13;
    localparam int PAGE_W_DEF = 5;

    // ----------------------------------------------------------------
    // control byte field positions
    // ----------------------------------------------------------------
    localparam int CB_RW      = 0;
    localparam int CB_CS_LO   = 1;
    localparam int CB_CS_HI   = 3;
    localparam int CB_CODE_LO = 4;
    localparam int CB_CODE_HI = 7;

    // ----------------------------------------------------------------
    // pin sampler slots
    // ----------------------------------------------------------------
    localparam int SI_SCL = 0;
    localparam int SI_SDA = 1;
    localparam int SI_WP  = 2;
    localparam int SI_CS0 = 3;
    localparam int SI_W   = 6;

    // ----------------------------------------------------------------
    // timing: internal write cycle
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int WR_TIME_NS    = 5000000;
    localparam int WR_CYCLES     = WR_TIME_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // states and byte roles
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SP_IDLE  = 3'b000,
        SP_RX    = 3'b001,
        SP_ACK   = 3'b010,
        SP_AHOLD = 3'b011,
        SP_TX    = 3'b100,
        SP_RACK  = 3'b101
    } sep_state_e;

    typedef enum logic [1:0] {
        SR_CTRL = 2'b00,
        SR_AHI  = 2'b01,
        SR_ALO  = 2'b10,
        SR_DATA = 2'b11
    } sep_role_e;

endpackage

// File: core/sep_core.sv
// two-wire serial memory target: addressing, reads, page writes, busy polling
// assumes bus pins arrive asynchronous to clk and are sampled here
`timescale 1ns/1ns
module sep_core
    import sep_pkg::*;
#(
    parameter int         ADDR_W      = ADDR_W_DEF,
    parameter int         PAGE_W      = PAGE_W_DEF,
    parameter int         WR_CYCLES_P = WR_CYCLES,
    // device type code: value is arbitrary
    parameter logic [3:0] DEV_CODE    = 4'h5
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // two-wire bus
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    // straps
    input  wire logic chip_select_bit0,
    input  wire logic chip_select_bit1,
    input  wire logic chip_select_bit2,
    input  wire logic wp_i,
    // status
    output logic      busy
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (ADDR_W < 9 || ADDR_W > 16 || PAGE_W < 1 || PAGE_W >= ADDR_W) begin : g_bad_w
        $error("sep_core: unsupported address or page width");
    end
    if (WR_CYCLES_P < (1 << PAGE_W)) begin : g_bad_t
        $error("sep_core: write cycle shorter than page commit");
    end

    localparam int PAGE_BYTES = 1 << PAGE_W;

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    logic [SI_W-1:0] pin_w;
    logic [SI_W-1:0] s1_r;
    logic [SI_W-1:0] s2_r;
    logic [SI_W-1:0] s3_r;
    logic [SI_W-1:0] f_r;
    logic [SI_W-1:0] fd_r;

    assign pin_w = {chip_select_bit2, chip_select_bit1, chip_select_bit0, wp_i, sda_i, scl_i};

    genvar gi;
    for (gi = 0; gi < SI_W; gi++) begin : g_sync
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                s1_r[gi] <= 1'b1;
                s2_r[gi] <= 1'b1;
                s3_r[gi] <= 1'b1;
                f_r[gi]  <= 1'b1;
                fd_r[gi] <= 1'b1;
            end else if (ce) begin
                s1_r[gi] <= pin_w[gi];
                s2_r[gi] <= s1_r[gi];
                s3_r[gi] <= s2_r[gi];
                if (s2_r[gi] == s3_r[gi]) begin
                    f_r[gi] <= s3_r[gi];
                end
                fd_r[gi] <= f_r[gi];
            end
        end
    end

    logic       scl_f;
    logic       sda_f;
    logic       wp_f;
    logic [2:0] cs_f;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_ev;
    logic       stop_ev;

    assign scl_f    = f_r[SI_SCL];
    assign sda_f    = f_r[SI_SDA];
    assign wp_f     = f_r[SI_WP];
    assign cs_f     = f_r[SI_CS0+2:SI_CS0];
    assign scl_rise = ce & scl_f & ~fd_r[SI_SCL];
    assign scl_fall = ce & ~scl_f & fd_r[SI_SCL];
    // data edge while clock stays high marks a bus condition
    assign start_ev = ce & scl_f & fd_r[SI_SCL] & fd_r[SI_SDA] & ~sda_f;
    assign stop_ev  = ce & scl_f & fd_r[SI_SCL] & ~fd_r[SI_SDA] & sda_f;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0]            mem_r [1 << ADDR_W];
    logic [7:0]            buf_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] vld_r;
    logic [PAGE_BYTES-1:0] cvld_r;
    logic [ADDR_W-1:0]     ptr_r;
    logic [7:0]            rd_byte;

    assign rd_byte = mem_r[ptr_r];

    // ----------------------------------------------------------------
    // serial state machine
    // ----------------------------------------------------------------
    sep_state_e st_r;
    sep_role_e  role_r;
    logic [2:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] hi_r;
    logic       rd_r;
    logic       oe_r;
    logic       busy_r;
    logic [7:0] byte_in;
    logic       ctrl_ok;
    logic       rx_done;
    logic       load_ev;

    assign byte_in = {sh_r[6:0], sda_f};
    assign rx_done = scl_rise && st_r == SP_RX && bit_r == 3'h7;
    assign load_ev = scl_fall && st_r == SP_AHOLD && rd_r;
    assign ctrl_ok = byte_in[CB_CODE_HI:CB_CODE_LO] == DEV_CODE
                  && byte_in[CB_CS_HI:CB_CS_LO] == cs_f
                  && !busy_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r   <= SP_IDLE;
            role_r <= SR_CTRL;
            bit_r  <= 3'h0;
            sh_r   <= 8'h00;
            hi_r   <= 8'h00;
            rd_r   <= 1'b0;
            oe_r   <= 1'b0;
            ptr_r  <= '0;
            vld_r  <= '0;
        end else if (ce) begin
            if (stop_ev) begin
                st_r  <= SP_IDLE;
                oe_r  <= 1'b0;
                vld_r <= '0;
            end else if (start_ev) begin
                st_r   <= SP_RX;
                role_r <= SR_CTRL;
                bit_r  <= 3'h0;
                oe_r   <= 1'b0;
                vld_r  <= '0;
            end else begin
                unique case (st_r)
                    SP_IDLE: st_r <= SP_IDLE;
                    SP_RX: if (scl_rise) begin
                        sh_r  <= byte_in;
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7) begin
                            st_r <= SP_ACK;
                            unique case (role_r)
                                SR_CTRL: begin
                                    rd_r   <= byte_in[CB_RW];
                                    role_r <= byte_in[CB_RW] ? SR_DATA : SR_AHI;
                                    if (!ctrl_ok) st_r <= SP_IDLE;
                                end
                                SR_AHI: begin
                                    hi_r   <= byte_in;
                                    role_r <= SR_ALO;
                                end
                                SR_ALO: begin
                                    // upper bits beyond the array drop out
                                    ptr_r  <= ADDR_W'({hi_r, byte_in});
                                    vld_r  <= '0;
                                    role_r <= SR_DATA;
                                end
                                SR_DATA: begin
                                    vld_r[ptr_r[PAGE_W-1:0]] <= 1'b1;
                                    ptr_r <= {ptr_r[ADDR_W-1:PAGE_W],
                                              PAGE_W'(ptr_r[PAGE_W-1:0] + 1'b1)};
                                end
                            endcase
                        end
                    end
                    SP_ACK: if (scl_fall) begin
                        oe_r <= 1'b1;
                        st_r <= SP_AHOLD;
                    end
                    SP_AHOLD: if (scl_fall) begin
                        bit_r <= 3'h0;
                        if (rd_r) begin
                            oe_r  <= ~rd_byte[7];
                            sh_r  <= {rd_byte[6:0], 1'b0};
                            ptr_r <= ptr_r + 1'b1;
                            st_r  <= SP_TX;
                        end else begin
                            oe_r <= 1'b0;
                            st_r <= SP_RX;
                        end
                    end
                    SP_TX: if (scl_fall) begin
                        if (bit_r == 3'h7) begin
                            oe_r <= 1'b0;
                            st_r <= SP_RACK;
                        end else begin
                            oe_r  <= ~sh_r[7];
                            sh_r  <= {sh_r[6:0], 1'b0};
                            bit_r <= bit_r + 3'h1;
                        end
                    end
                    SP_RACK: if (scl_rise) begin
                        st_r <= sda_f ? SP_IDLE : SP_AHOLD;
                    end
                    default: st_r <= SP_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // page buffer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (ce && rx_done && role_r == SR_DATA && !rd_r) begin
            buf_r[ptr_r[PAGE_W-1:0]] <= byte_in;
        end
    end

    // ----------------------------------------------------------------
    // self-timed write cycle
    // ----------------------------------------------------------------
    logic                     commit_go;
    logic [31:0]              tmr_r;
    logic [PAGE_W:0]          cidx_r;
    logic [ADDR_W-PAGE_W-1:0] page_r;

    assign commit_go = stop_ev && (|vld_r) && !wp_f && !busy_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_r <= 1'b0;
            tmr_r  <= 32'h0;
            cidx_r <= '0;
            page_r <= '0;
            cvld_r <= '0;
        end else if (ce) begin
            if (commit_go) begin
                busy_r <= 1'b1;
                tmr_r  <= 32'(WR_CYCLES_P - 1);
                cidx_r <= '0;
                page_r <= ptr_r[ADDR_W-1:PAGE_W];
                cvld_r <= vld_r;
            end else if (busy_r) begin
                busy_r <= tmr_r != 32'h0;
                tmr_r  <= tmr_r - 32'h1;
                if (!cidx_r[PAGE_W]) begin
                    cidx_r <= cidx_r + 1'b1;
                end
            end
        end
    end

    // one buffered byte per cycle moves into the array while busy
    always_ff @(posedge clk) begin
        if (ce && busy_r && !cidx_r[PAGE_W] && cvld_r[cidx_r[PAGE_W-1:0]]) begin
            mem_r[{page_r, cidx_r[PAGE_W-1:0]}] <= buf_r[cidx_r[PAGE_W-1:0]];
        end
    end

    // open drain: the data level is always low, only the enable moves
    assign sda_o  = 1'b0;
    assign sda_oe = oe_r;
    assign busy   = busy_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_BUSY_NO_ACK: assert property (
        rx_done && role_r == SR_CTRL && busy_r |=> st_r == SP_IDLE ##1 !sda_oe
    ) else $error("control byte taken while busy");
    AST_CS_MATCH: assert property (
        rx_done && role_r == SR_CTRL && byte_in[CB_CS_HI:CB_CS_LO] != cs_f |=> st_r == SP_IDLE
    ) else $error("mismatched select answered");
    AST_DRIVE_PHASE: assert property (
        sda_oe |-> st_r == SP_AHOLD || st_r == SP_TX
    ) else $error("data line driven outside ack or data");
    AST_STOP_IDLE: assert property (
        stop_ev |=> st_r == SP_IDLE && !sda_oe) else $error("stop did not idle");
    AST_START_SYNC: assert property (
        start_ev && !stop_ev |=> st_r == SP_RX && bit_r == 3'h0 && role_r == SR_CTRL
    ) else $error("start did not resync");
    AST_PTR_INC: assert property (
        load_ev && !start_ev && !stop_ev |=> ptr_r == ADDR_W'($past(ptr_r) + 1'b1)
    ) else $error("pointer did not advance");
    AST_TX_MSB: assert property (
        load_ev && !start_ev && !stop_ev |=> sda_oe == !$past(rd_byte[7])
    ) else $error("first data bit wrong");
    AST_PAGE_WRAP: assert property (
        rx_done && role_r == SR_DATA && !rd_r && !start_ev && !stop_ev
        |=> ptr_r[ADDR_W-1:PAGE_W] == $past(ptr_r[ADDR_W-1:PAGE_W])
    ) else $error("page write left its page");
    AST_WP_BLOCK: assert property (
        stop_ev && wp_f && !busy_r |=> !busy_r) else $error("protected write started a cycle");
    AST_NACK_RELEASE: assert property (
        scl_rise && st_r == SP_RACK && sda_f && !stop_ev |=> st_r == SP_IDLE ##1 !sda_oe [*2]
    ) else $error("line held after master nack");

    COV_WRITE: cover property (commit_go);
    COV_SEQ_READ: cover property (scl_rise && st_r == SP_RACK && !sda_f);
    COV_POLL_NACK: cover property (rx_done && role_r == SR_CTRL && busy_r);
    COV_WRAP: cover property (load_ev && ptr_r == '1);

endmodule

// File: bench/sep_bus_master.sv
// bus controller model: drives the serial clock and pulls the data line low
// assumes the bench resolves the data wire with a pull-up to high
`timescale 1ns/1ns
module sep_bus_master (
    // two-wire bus
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda_line
);
    // quarter of the 125 ns bit period
    localparam int Q = 31;

    // clock stands high between frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ------------------------------------------------------------
    // bus conditions, data moves while clock high only here
    // ------------------------------------------------------------
    // works from idle and mid-frame, so it also gives a repeated start
    task automatic start_cond();
        sda_pull <= 1'b0;
        #Q;
        scl <= 1'b1;
        #Q;
        sda_pull <= 1'b1;
        #Q;
        scl <= 1'b0;
        #(Q + 1);
    endtask

    task automatic stop_cond();
        sda_pull <= 1'b1;
        #Q;
        scl <= 1'b1;
        #Q;
        sda_pull <= 1'b0;
        #(2 * Q + 1);
    endtask

    // ------------------------------------------------------------
    // bits and bytes, msb first
    // ------------------------------------------------------------
    task automatic bit_xfer(input logic b, output logic s);
        sda_pull <= ~b;
        #Q;
        scl <= 1'b1;
        #Q;
        s = sda_line;
        #Q;
        scl <= 1'b0;
        #(Q + 1);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask

    // a withheld ack ends a read sequence
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(~mack, s);
    endtask
endmodule

// File: bench/test_serial_eeprom_read_and_poll.sv
// self-checking bench for the serial memory target: writes, polling, reads
// assumes sep_core and the bus controller model sep_bus_master
`timescale 1ns/1ns
module test_serial_eeprom_read_and_poll;
    import sep_pkg::*;

    localparam int         WR_CYC = 600;
    // device type code: value is arbitrary
    localparam logic [3:0] DEV    = 4'h6;
    localparam logic [2:0] CS     = 3'h5;

    logic       clk;
    logic       sys_rst;
    logic       ce;
    logic       wp_r;
    logic [2:0] cs_r;
    logic       scl;
    logic       sda_pull;
    logic       sda_line;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    int         err_count;
    int         checks_done;

    // open-drain wire with pull-up
    assign sda_line = !(sda_pull | (sda_oe & ~sda_o));

    sep_core #(.WR_CYCLES_P(WR_CYC), .DEV_CODE(DEV)) u_sep_core (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_bit0(cs_r[0]),
        .chip_select_bit1(cs_r[1]), .chip_select_bit2(cs_r[2]), .wp_i(wp_r), .busy(busy));

    sep_bus_master u_sep_bus_master (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // checking and bus helpers
    // ------------------------------------------------------------
    task automatic summarize();
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] ctl(input logic [3:0] code, input logic [2:0] cs,
                                       input logic rw);
        return {code, cs, rw};
    endfunction

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        u_sep_bus_master.write_byte(d, ack);
        check("ack", {7'h0, ack}, {7'h0, exp_ack});
    endtask

    task automatic send_addr(input logic [15:0] a);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
    endtask

    // repeated start and read control byte when restart is set, then one byte
    task automatic rd(input logic [7:0] exp, input logic mack, input logic restart);
        logic [7:0] d;
        if (restart) begin
            u_sep_bus_master.start_cond();
            send(ctl(DEV, CS, 1'b1), 1'b1);
        end
        u_sep_bus_master.read_byte(mack, d);
        check("read data", d, exp);
    endtask

    task automatic write3(input logic [15:0] a, input logic [7:0] d0, d1, d2);
        u_sep_bus_master.start_cond();
        send(ctl(DEV, CS, 1'b0), 1'b1);
        send_addr(a);
        send(d0, 1'b1);
        send(d1, 1'b1);
        send(d2, 1'b1);
        u_sep_bus_master.stop_cond();
    endtask

    // polls right after the stop and leaves the acked transaction open
    task automatic poll(input logic [7:0] exp_nacks);
        logic ack;
        int   nacks;
        ack   = 1'b0;
        nacks = 0;
        while (ack !== 1'b1 && nacks < 10) begin
            u_sep_bus_master.start_cond();
            u_sep_bus_master.write_byte(ctl(DEV, CS, 1'b0), ack);
            if (ack !== 1'b1) begin
                nacks++;
            end
        end
        check("poll ack", {7'h0, ack}, 8'h01);
        check("busy at poll ack", {7'h0, busy}, 8'h00);
        if (exp_nacks == 8'h00) begin
            check("poll retries", nacks[7:0], 8'h00);
        end else begin
            check("poll refused", {7'h0, nacks > 0}, 8'h01);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // page write crossing the page end, then random read of the wrapped byte
    task automatic sc_page_write();
        write3(16'hfffe, 8'h11, 8'h22, 8'h33);
        check("busy after stop", {7'h0, busy}, 8'h01);
        // clock enable low must hold the write timer where it stands
        @(posedge clk);
        ce <= 1'b0;
        repeat (WR_CYC + 100) @(posedge clk);
        check("busy frozen", {7'h0, busy}, 8'h01);
        ce <= 1'b1;
        poll(8'h01);
        send_addr(16'h1fe0);
        rd(8'h33, 1'b0, 1'b1);
        u_sep_bus_master.stop_cond();
    endtask

    // late protect toggle, sequential read over the top, current address read
    task automatic sc_wrap_read();
        write3(16'h0000, 8'h44, 8'h55, 8'h66);
        @(posedge clk);
        wp_r <= 1'b1;
        poll(8'h01);
        send_addr(16'h1ffe);
        rd(8'h11, 1'b1, 1'b1);
        rd(8'h22, 1'b1, 1'b0);
        rd(8'h44, 1'b1, 1'b0);
        rd(8'h55, 1'b0, 1'b0);
        u_sep_bus_master.stop_cond();
        u_sep_bus_master.start_cond();
        send(ctl(DEV, CS, 1'b1), 1'b1);
        rd(8'h66, 1'b0, 1'b0);
        u_sep_bus_master.stop_cond();
    endtask

    // protected write is acked but stores nothing and starts no cycle
    task automatic sc_protect();
        write3(16'h0001, 8'h77, 8'h78, 8'h79);
        check("busy protected", {7'h0, busy}, 8'h00);
        poll(8'h00);
        send_addr(16'h0001);
        rd(8'h55, 1'b0, 1'b1);
        u_sep_bus_master.stop_cond();
        @(posedge clk);
        wp_r <= 1'b0;
    endtask

    // each select bit and the type code mismatched in turn
    task automatic sc_select();
        for (int i = 0; i < 4; i++) begin
            u_sep_bus_master.start_cond();
            if (i < 3) begin
                send(ctl(DEV, CS ^ (3'h1 << i), 1'b0), 1'b0);
            end else begin
                send(ctl(DEV ^ 4'h1, CS, 1'b1), 1'b0);
            end
            u_sep_bus_master.stop_cond();
        end
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk         = 1'b0;
        sys_rst     = 1'b1;
        ce          = 1'b1;
        wp_r        = 1'b0;
        cs_r        = CS;
        err_count   = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        sc_page_write();
        sc_wrap_read();
        sc_protect();
        sc_select();
        summarize();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule
